// file: pipe_ctrl_pkg.sv
// Summary of operation
// - Every instruction passes five overlapping stages and a new one may enter each cycle.
// - The stages in order are fetch, decode, operate, memory access and register write.
// - An accepted interrupt always leads to the handler entry, even if the request is withdrawn.
// - Traps come from the instruction stream and, once accepted, are never withdrawn.
// - Peripheral interrupts are accepted only while the global interrupt enable flag is set.
// - A read of a register still pending a write by an older instruction is corrected or stalled.
// - A result available at the end of the operate stage is forwarded to the next instruction's operate stage with no stall.
// - A load result needed by the next instruction holds that instruction in decode one cycle.
package pipe_ctrl_pkg;

    localparam int REG_AW = 4;

    typedef struct packed {
        logic              valid;
        logic              trap;
        logic              writes;
        logic              is_load;
        logic              use_a;
        logic              use_b;
        logic [REG_AW-1:0] rd;
        logic [REG_AW-1:0] ra;
        logic [REG_AW-1:0] rb;
    } instr_t;

    localparam instr_t BUBBLE = '0;

    typedef enum logic [1:0] {
        FWD_NONE = 2'h0,
        FWD_ALU  = 2'h1,
        FWD_MEM  = 2'h2,
        FWD_WB   = 2'h3
    } fwd_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_DRAIN = 2'h1,
        ST_ENTRY = 2'h2
    } fsm_t;

    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_IRQ  = 2'h1,
        CAUSE_TRAP = 2'h2
    } cause_t;

    typedef struct packed {
        logic   irq_meta;
        logic   irq_sync;
        instr_t de;
        instr_t ex;
        instr_t ma;
        instr_t wb;
        fwd_t   fwd_a;
        fwd_t   fwd_b;
        fsm_t   fsm;
        cause_t cause;
        logic   fetch_hold;
        logic   entry_start;
    } state_t;

endpackage

// file: pipeline_hazard_control.sv
`timescale 1ns/100ps
module pipeline_hazard_control
    import pipe_ctrl_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire instr_t fetch_instr,
    input  wire logic   irq_request,
    input  wire logic   int_enable,
    output instr_t      decode_stage,
    output instr_t      alu_stage,
    output instr_t      memory_stage,
    output instr_t      register_write_stage,
    output fwd_t        fwd_a,
    output fwd_t        fwd_b,
    output logic        fetch_hold,
    output logic        entry_start,
    output cause_t      entry_cause
);

    state_t s;
    state_t next_s;
    logic   stall;
    logic   accept_irq;
    logic   accept_trap;

    // Consumer reads a register that the producer is about to write
    function automatic logic reads_dest(input instr_t c, input instr_t p);
        return c.valid && p.valid && p.writes &&
               ((c.use_a && c.ra == p.rd) || (c.use_b && c.rb == p.rd));
    endfunction

    function automatic logic load_hazard(input instr_t c, input instr_t p);
        return reads_dest(c, p) && p.is_load;
    endfunction

    // Youngest producer wins
    function automatic fwd_t pick_fwd(input logic use_r, input logic [REG_AW-1:0] r,
                                      input instr_t ex, input instr_t ma, input instr_t wb);
        if (!use_r)
            return FWD_NONE;
        else if (ex.valid && ex.writes && !ex.is_load && ex.rd == r)
            return FWD_ALU;
        else if (ma.valid && ma.writes && ma.rd == r)
            return FWD_MEM;
        else if (wb.valid && wb.writes && wb.rd == r)
            return FWD_WB;
        else
            return FWD_NONE;
    endfunction

    assign stall       = load_hazard(s.de, s.ex);
    assign accept_trap = s.fsm == ST_RUN && s.de.valid && s.de.trap;
    assign accept_irq  = s.fsm == ST_RUN && !accept_trap && s.irq_sync && int_enable;

    always_comb begin
        next_s             = s;
        next_s.irq_meta    = irq_request;
        next_s.irq_sync    = s.irq_meta;
        next_s.entry_start = 1'b0;
        // Older stages always advance
        next_s.wb          = s.ma;
        next_s.ma          = s.ex;
        unique case (s.fsm)
            ST_RUN: begin
                if (accept_trap || accept_irq) begin
                    // Cancel younger work; the request is latched as cause
                    next_s.de    = BUBBLE;
                    next_s.ex    = BUBBLE;
                    next_s.fwd_a = FWD_NONE;
                    next_s.fwd_b = FWD_NONE;
                    next_s.fsm   = ST_DRAIN;
                    next_s.cause = accept_trap ? CAUSE_TRAP : CAUSE_IRQ;
                end else if (stall) begin
                    next_s.ex    = BUBBLE;
                    next_s.fwd_a = FWD_NONE;
                    next_s.fwd_b = FWD_NONE;
                end else begin
                    next_s.ex    = s.de;
                    next_s.fwd_a = pick_fwd(s.de.use_a, s.de.ra, s.ex, s.ma, s.wb);
                    next_s.fwd_b = pick_fwd(s.de.use_b, s.de.rb, s.ex, s.ma, s.wb);
                    next_s.de    = fetch_instr;
                end
            end
            ST_DRAIN: begin
                next_s.de    = BUBBLE;
                next_s.ex    = BUBBLE;
                next_s.fwd_a = FWD_NONE;
                next_s.fwd_b = FWD_NONE;
                // Entry only once every older instruction has written back
                if (!s.ex.valid && !s.ma.valid && !s.wb.valid) begin
                    next_s.fsm         = ST_ENTRY;
                    next_s.entry_start = 1'b1;
                end
            end
            ST_ENTRY: begin
                next_s.de  = BUBBLE;
                next_s.ex  = BUBBLE;
                next_s.fsm = ST_RUN;
            end
            default: begin
                next_s = '0;
            end
        endcase
        next_s.fetch_hold = load_hazard(next_s.de, next_s.ex) || next_s.fsm != ST_RUN;
    end

    always_ff @(posedge clk) begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign decode_stage         = s.de;
    assign alu_stage            = s.ex;
    assign memory_stage         = s.ma;
    assign register_write_stage = s.wb;
    assign fwd_a                = s.fwd_a;
    assign fwd_b                = s.fwd_b;
    assign fetch_hold           = s.fetch_hold;
    assign entry_start          = s.entry_start;
    assign entry_cause          = s.cause;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence drained;
        !alu_stage.valid && !memory_stage.valid && !register_write_stage.valid;
    endsequence

    sequence entry_for(cause_t c);
        entry_start && entry_cause == c;
    endsequence

    a_stage_shift: assert property (
        memory_stage.valid |=> register_write_stage == $past(memory_stage))
        else $error("memory stage did not move to register write");

    a_steady_issue: assert property (
        s.fsm == ST_RUN && !stall && !accept_irq && !accept_trap && decode_stage.valid
        |=> alu_stage == $past(decode_stage))
        else $error("decode did not issue without hazard");

    // Load-use hold: a bubble goes to operate while decode keeps its instruction
    sequence held_in_decode;
        !alu_stage.valid && decode_stage == $past(decode_stage);
    endsequence

    // The held consumer issues next, unless an accepted request cancelled it
    sequence issued_after_hold;
        s.fsm != ST_RUN || (alu_stage == $past(decode_stage, 2) && fwd_a != FWD_ALU);
    endsequence

    a_load_use_stall: assert property (
        s.fsm == ST_RUN && !accept_irq && !accept_trap && stall
        |-> fetch_hold ##1 held_in_decode ##1 issued_after_hold)
        else $error("load use hold wrong");

    a_load_fwd_mem: assert property (
        s.fsm == ST_RUN && !accept_irq && !accept_trap && stall &&
        decode_stage.use_b && decode_stage.rb == alu_stage.rd
        |=> ##1 (s.fsm != ST_RUN || fwd_b == FWD_MEM))
        else $error("loaded operand not taken from memory stage");

    a_alu_forward: assert property (
        s.fsm == ST_RUN && !accept_irq && !accept_trap && decode_stage.use_a &&
        alu_stage.valid && alu_stage.writes && !alu_stage.is_load &&
        decode_stage.valid && decode_stage.ra == alu_stage.rd
        |=> fwd_a == FWD_ALU && alu_stage.valid)
        else $error("operate result not forwarded");

    a_irq_masked: assert property (
        s.fsm == ST_RUN && !int_enable && !(decode_stage.valid && decode_stage.trap)
        |=> s.fsm == ST_RUN)
        else $error("interrupt taken while disabled");

    a_irq_committed: assert property (
        accept_irq |-> ##[2:5] entry_for(CAUSE_IRQ))
        else $error("accepted interrupt did not reach entry");

    a_trap_entry: assert property (
        accept_trap |-> ##[2:5] entry_for(CAUSE_TRAP))
        else $error("accepted trap did not reach entry");

    a_cancel_young: assert property (
        (accept_irq || accept_trap) |=> !decode_stage.valid && !alu_stage.valid)
        else $error("younger instructions not cancelled");

    a_entry_drained: assert property (
        $rose(entry_start) |-> drained)
        else $error("entry started before older work completed");

    a_no_stale_read: assert property (
        alu_stage.valid && $past(s.fsm) == ST_RUN
        |-> !($past(alu_stage.valid) && $past(alu_stage.is_load) && $past(alu_stage.writes) &&
              alu_stage.use_a && alu_stage.ra == $past(alu_stage.rd)
              && alu_stage == $past(decode_stage)))
        else $error("load result read before available");

    a_entry_pulse: assert property (
        entry_start |=> !entry_start && !fetch_hold && s.fsm == ST_RUN)
        else $error("entry pulse longer than one cycle");

    a_drain_holds_fetch: assert property (
        s.fsm != ST_RUN |-> fetch_hold && !decode_stage.valid)
        else $error("fetch not held while draining");

    a_drain_bounded: assert property (
        s.fsm == ST_DRAIN |-> ##[1:3] s.fsm == ST_ENTRY)
        else $error("drain did not end in entry");

    a_cause_kept: assert property (
        s.fsm != ST_RUN |=> $stable(entry_cause))
        else $error("latched entry cause changed before entry");

    a_trap_first: assert property (
        s.fsm == ST_RUN && decode_stage.valid && decode_stage.trap
        |=> entry_cause == CAUSE_TRAP && s.fsm == ST_DRAIN)
        else $error("trap in decode not accepted");

endmodule // pipeline_hazard_control

// file: fetch_source.sv
`timescale 1ns/100ps
module fetch_source
    import pipe_ctrl_pkg::*;
(
    input  wire logic clk,
    input  wire logic restart,
    input  wire logic fetch_hold,
    output instr_t    fetch_instr
);
    instr_t     prog [0:3];
    logic [2:0] pc;
    // While restarting and past the end of the program the line carries only bubbles
    assign fetch_instr = (restart || pc[2]) ? BUBBLE : prog[pc[1:0]];
    always_ff @(posedge clk) begin
        if (restart) begin
            pc <= 3'h0;
        end else if (!fetch_hold && !pc[2]) begin
            pc <= pc + 3'h1;
        end
    end
endmodule // fetch_source

// file: test_pipeline_hazard_control.sv
`timescale 1ns/100ps
module test_pipeline_hazard_control;
    import pipe_ctrl_pkg::*;
    logic   clk = 1'b0;
    logic   rst = 1'b1;
    logic   restart = 1'b1;
    logic   irq_request = 1'b0;
    logic   int_enable = 1'b0;
    instr_t fetch_instr, dec, alu, mem, wrs;
    fwd_t   fwd_a, fwd_b;
    logic   fetch_hold, entry_start;
    cause_t entry_cause;
    int     mismatches = 0;
    int     n_tests = 0;
    instr_t a, b;

    fetch_source fsrc (.clk(clk), .restart(restart), .fetch_hold(fetch_hold),
                       .fetch_instr(fetch_instr));
    pipeline_hazard_control uut (.clk(clk), .rst(rst), .fetch_instr(fetch_instr),
        .irq_request(irq_request), .int_enable(int_enable), .decode_stage(dec),
        .alu_stage(alu), .memory_stage(mem), .register_write_stage(wrs),
        .fwd_a(fwd_a), .fwd_b(fwd_b), .fetch_hold(fetch_hold),
        .entry_start(entry_start), .entry_cause(entry_cause));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_i(string what, instr_t exp, instr_t got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_v(string what, logic [1:0] exp, logic [1:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    // Flags are trap, writes, is_load, use_a, use_b
    function automatic instr_t mk(logic [4:0] f, logic [3:0] rd, ra, rb);
        return instr_t'({1'b1, f, rd, ra, rb});
    endfunction

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Program is loaded while the partner shows bubbles, so no half-loaded word is fetched
    task automatic start(instr_t p0, instr_t p1);
        @(posedge clk) restart <= 1'b1;
        @(posedge clk);
        #1;
        fsrc.prog[0] = p0;
        fsrc.prog[1] = p1;
        @(posedge clk) restart <= 1'b0;
    endtask

    task automatic wait_entry(logic exp_go, cause_t exp);
        int n = 0;
        #1;
        while (entry_start !== 1'b1 && n < 10) begin
            step();
            n++;
        end
        chk_v("entry", {1'b0, exp_go}, {1'b0, entry_start});
        if (exp_go) begin
            chk_v("cause", exp, entry_cause);
            chk_i("drained", BUBBLE, alu);
        end
        repeat (3) step();
    endtask

    task automatic test_reset_state();
        chk_i("decode at reset", BUBBLE, dec);
        chk_v("pulse at reset", 2'h0, {entry_start, fetch_hold});
    endtask

    task automatic test_issue();
        a = mk(5'h08, 4'h3, 4'h0, 4'h0);
        b = mk(5'h08, 4'h4, 4'h0, 4'h0);
        start(a, b);
        step();
        chk_i("decode", a, dec);
        step();
        chk_i("operate", a, alu);
        chk_i("decode next", b, dec);
        step();
        chk_i("memory", a, mem);
        chk_i("operate next", b, alu);
        step();
        chk_i("write", a, wrs);
        chk_i("memory next", b, mem);
    endtask

    task automatic test_alu_forward();
        b = mk(5'h02, 4'h5, 4'h1, 4'h0);
        start(mk(5'h08, 4'h1, 4'h0, 4'h0), b);
        step();
        step();
        chk_v("no stall", 2'h0, {1'b0, fetch_hold});
        step();
        chk_i("fwd user", b, alu);
        chk_v("fwd a", FWD_ALU, fwd_a);
    endtask

    task automatic test_load_stall();
        b = mk(5'h01, 4'h6, 4'h0, 4'h2);
        start(mk(5'h0C, 4'h2, 4'h0, 4'h0), b);
        step();
        step();
        chk_v("hold", 2'h1, {1'b0, fetch_hold});
        step();
        chk_i("bubble", BUBBLE, alu);
        chk_i("held", b, dec);
        step();
        chk_i("load user", b, alu);
        chk_v("fwd b", FWD_MEM, fwd_b);
        repeat (4) step();
    endtask

    // Request is withdrawn at the very edge on which it is accepted
    task automatic test_irq_taken();
        start(a, a);
        int_enable <= 1'b1;
        @(posedge clk) irq_request <= 1'b1;
        repeat (3) @(posedge clk);
        irq_request <= 1'b0;
        wait_entry(1'b1, CAUSE_IRQ);
    endtask

    task automatic test_irq_masked();
        @(posedge clk) int_enable <= 1'b0;
        @(posedge clk) irq_request <= 1'b1;
        wait_entry(1'b0, CAUSE_NONE);
        @(posedge clk) irq_request <= 1'b0;
    endtask

    task automatic test_trap();
        start(mk(5'h10, 4'h0, 4'h0, 4'h0), BUBBLE);
        wait_entry(1'b1, CAUSE_TRAP);
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            fsrc.prog[i] = BUBBLE;
        end
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        restart <= 1'b0;
        #1;
        test_reset_state();
        test_issue();
        test_alu_forward();
        test_load_stall();
        test_irq_taken();
        test_irq_masked();
        test_trap();
        end_sim();
    end

    initial begin
        #(400 * 100);
        mismatches++;
        end_sim();
    end
endmodule // test_pipeline_hazard_control
